// [bench/clk_src.sv]
// Slow input clock source for the divider bench.
// Assumes hp is at least 2, so clk_in stays below clk/2.
`timescale 1ns/1ps
`default_nettype none
module clk_src
(
  // System clock
  input  wire logic       clk,
  // Half period in clk cycles
  input  wire logic [2:0] hp,
  // Slow clock level
  output var  logic       clk_in
);
  logic [2:0] cnt_r;
  initial clk_in = 1'h0;
  initial cnt_r = 3'h0;
  // Toggle off the sampling edge; a shrinking hp wraps at once
  always @(negedge clk)
  begin
    if (cnt_r >= hp - 3'h1)
    begin
      cnt_r  <= 3'h0;
      clk_in <= ~clk_in;
    end
    else
      cnt_r <= cnt_r + 3'h1;
  end
endmodule : clk_src
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the 2/4/8 divider.
// Assumes the design and clk_src are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clkdiv_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ce = 1'h1;
  logic        frz = 1'h0;
  logic        clr = 1'h0;
  logic [2:0]  hp = 3'h2;
  logic        clk_in;
  ctrl_in_t    pins;
  div_out_t    outs;
  logic [31:0] seed = 32'hdc9e;
  logic [2:0]  exp_q[$];
  logic [2:0]  cnt_m, old_m, cur, seen_r;
  logic        p_clk, p_clr, skip_m, frz_m, rise;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 clk = ~clk;
  assign pins = '{clk_in: clk_in, freeze: frz, sync_clear: clr};
  clk_src src_u (.clk(clk), .hp(hp), .clk_in(clk_in));
  sync_clock_divider_2_4_8 dut_u
    (.clk(clk), .rst(rst), .ce(ce), .pins(pins), .outs(outs));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [2:0] e,
                       input logic [2:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Reference divider; notes each predicted count in order, so the
  // comparison does not depend on the design's pipeline depth
  always @(posedge clk)
  begin
    old_m = cnt_m;
    if (rst)
    begin
      cnt_m = 3'h0;
      p_clk = 1'h0;
      p_clr = 1'h0;
      skip_m = 1'h0;
      frz_m = 1'h0;
    end
    else if (ce)
    begin
      rise = clk_in & ~p_clk;
      if (clr === 1'h1)
        cnt_m = 3'h0;
      else if (rise && !frz_m && !skip_m)
        cnt_m = cnt_m + 3'h1;
      if (rise)
        skip_m = 1'h0;
      if (p_clr && clr !== 1'h1 && !clk_in)
        skip_m = 1'h1;
      if (!clk_in && p_clk)
        frz_m = (frz === 1'h1);
      p_clk = clk_in;
      p_clr = (clr === 1'h1);
    end
    // No note for the reset load; the watcher is idle then
    if (!rst && cnt_m !== old_m)
      exp_q.push_back(cnt_m);
  end

  // Watcher: every change of the outputs takes the oldest note
  always @(negedge clk)
  begin
    cur = {outs.eighth_rate_out, outs.quarter_rate_out,
           outs.half_rate_out};
    check("complement", cur, ~{outs.eighth_rate_out_n,
          outs.quarter_rate_out_n, outs.half_rate_out_n});
    if (rst)
      seen_r = 3'h0;
    else if (cur !== seen_r)
    begin
      if (exp_q.size() == 0)
        check("count", seen_r, cur);
      else
        check("count", exp_q.pop_front(), cur);
      seen_r = cur;
    end
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // Stimulus at the falling edge; actions spaced so they never overlap
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'h0;
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
    for (int i = 0; i < 120; i++)
    begin
      seed = lfsr(seed);
      hp = 3'h2 + {1'h0, seed[9:8]};
      case (seed[1:0])
        2'h0: frz = 1'h1;
        2'h1: clr = 1'h1;
        2'h2: ce = 1'h0;
        default: frz = 1'hz;
      endcase
      repeat (1 + seed[7:2]) @(negedge clk);
      frz = 1'h0;
      clr = 1'h0;
      ce = 1'h1;
      repeat (40) @(negedge clk);
    end
    check("pending", 3'h0, 3'(exp_q.size()));
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// [hdl/div_counter.sv]
// Three-stage divider counter with registered true and complement bits.
// Assumes step and clear are synchronous to clk and mutually resolved above.
`timescale 1ns/1ps
`default_nettype none

module div_counter
  import clkdiv_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Control
  input  wire logic                 clear,
  input  wire logic                 step,
  // Stage outputs
  output var  logic [DIV_BITS-1:0]  count_r,
  output var  logic [DIV_BITS-1:0]  count_n_r
);

  logic [DIV_BITS-1:0] count_nxt;

  // Clear beats step so alignment across devices is deterministic
  always_comb
  begin
    if (clear)
      count_nxt = COUNT_RESET;
    else if (step)
      count_nxt = count_r + COUNT_STEP;
    else
      count_nxt = count_r;
  end

  // One counter, one clock: every common edge lands together
  always_ff @(posedge clk)
  begin
    if (rst)
      count_r <= COUNT_RESET;
    else if (ce)
      count_r <= count_nxt;
  end

  // Complement kept in its own flops so both legs switch on one edge
  genvar i;
  generate
    for (i = 0; i < DIV_BITS; i++)
    begin : g_comp
      always_ff @(posedge clk)
      begin
        if (rst)
          count_n_r[i] <= ~COUNT_RESET[i];
        else if (ce)
          count_n_r[i] <= ~count_nxt[i];
      end
    end
  endgenerate

endmodule : div_counter

`default_nettype wire

// [hdl/sync_clock_divider_2_4_8.sv]
// Synchronous divide-by-2/4/8 generator with freeze and clear controls.
// Assumes clk runs much faster than the divided input clock, whose level
// is sampled here; all pins are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module sync_clock_divider_2_4_8
(
  // Clock, reset and enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Divider pins
  input  wire clkdiv_pkg::ctrl_in_t pins,
  // Divided outputs
  output var  clkdiv_pkg::div_out_t outs
);

  import clkdiv_pkg::*;

  // Anything not a clean one counts as low, like a pulled-down pin
  // Case match, so X and Z land on the default rather than spread
  function automatic logic as_level(input logic x);
    case (x)
      1'b1:    as_level = 1'b1;
      default: as_level = 1'b0;
    endcase
  endfunction : as_level

  logic                clk_lvl;
  logic                freeze_lvl;
  logic                clear_lvl;
  logic                clk_in_r;
  logic                clear_r;
  logic                freeze_r;
  logic                skip_r;
  logic                rise;
  logic                fall;
  logic                step;
  logic [DIV_BITS-1:0] count_r;
  logic [DIV_BITS-1:0] count_n_r;

  // Pin levels with open inputs treated as low
  assign clk_lvl    = as_level(pins.clk_in);
  assign freeze_lvl = as_level(pins.freeze);
  assign clear_lvl  = as_level(pins.sync_clear);

  // Previous input clock and clear levels for edge finding
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_in_r <= 1'b0;
      clear_r  <= 1'b0;
    end
    else if (ce)
    begin
      clk_in_r <= clk_lvl;
      clear_r  <= clear_lvl;
    end
  end

  // Edges of the input clock; a low reset sample matches its idle level
  assign rise = clk_lvl & ~clk_in_r;
  assign fall = ~clk_lvl & clk_in_r;

  // Freeze flop on the falling edge; it is stable across every rising
  // edge, so gating can never shorten an internal clock pulse
  always_ff @(posedge clk)
  begin
    if (rst)
      freeze_r <= FREEZE_RESET;
    else if (ce && fall)
      freeze_r <= freeze_lvl;
  end

  // Release while low costs one extra rising edge before counting
  always_ff @(posedge clk)
  begin
    if (rst)
      skip_r <= 1'b0;
    else if (ce)
    begin
      if (clear_lvl)
        skip_r <= 1'b0;
      else if (clear_r && !clk_lvl)
        skip_r <= 1'b1;
      else if (rise)
        skip_r <= 1'b0;
    end
  end

  // Advance on rising edges unless frozen, cleared or skipping
  assign step = rise & ~freeze_r & ~skip_r & ~clear_lvl;

  div_counter u_div_counter (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .clear     (clear_lvl),
    .step      (step),
    .count_r   (count_r),
    .count_n_r (count_n_r)
  );

  // Straight from counter flops, true and complement legs
  assign outs.half_rate_out      = count_r[HALF_BIT];
  assign outs.half_rate_out_n    = count_n_r[HALF_BIT];
  assign outs.quarter_rate_out   = count_r[QUARTER_BIT];
  assign outs.quarter_rate_out_n = count_n_r[QUARTER_BIT];
  assign outs.eighth_rate_out    = count_r[EIGHTH_BIT];
  assign outs.eighth_rate_out_n  = count_n_r[EIGHTH_BIT];

  // Checks on the divider behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_step;
    ce && step |=> count_r == $past(count_r) + COUNT_STEP;
  endproperty
  a_step: assert property (p_step) else $error("divider did not step");

  property p_hold;
    ce && freeze_r && !clear_lvl |=> $stable(count_r);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen divider moved");

  property p_clear;
    ce && clear_lvl |=> count_r == COUNT_RESET && count_n_r == ~COUNT_RESET;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not applied");

  property p_comp;
    count_n_r == ~count_r;
  endproperty
  a_comp: assert property (p_comp) else $error("complement mismatch");

  property p_freeze_on;
    ce && fall && freeze_lvl |=> freeze_r;
  endproperty
  a_freeze_on: assert property (p_freeze_on) else $error("freeze missed");

  property p_freeze_off;
    ce && fall && !freeze_lvl |=> !freeze_r;
  endproperty
  a_freeze_off: assert property (p_freeze_off) else $error("no resume");

  property p_freeze_quiet;
    !(ce && fall) |=> $stable(freeze_r);
  endproperty
  a_freeze_quiet: assert property (p_freeze_quiet)
    else $error("freeze changed off a falling edge");

  property p_rel_low;
    ce && clear_r && !clear_lvl && !clk_lvl |=> skip_r;
  endproperty
  a_rel_low: assert property (p_rel_low) else $error("no skip");

  property p_rel_high;
    ce && clear_r && !clear_lvl && clk_lvl |=> !skip_r;
  endproperty
  a_rel_high: assert property (p_rel_high) else $error("bad skip");

  property p_aligned;
    ce && !clear_lvl && $changed(count_r[QUARTER_BIT]) |->
      $fell(count_r[HALF_BIT]) || $past(clear_lvl);
  endproperty
  a_aligned: assert property (p_aligned) else $error("edges misaligned");

  property p_frozen_gap;
    ce && clk_lvl && !clk_in_r |-> $stable(freeze_r);
  endproperty
  a_frozen_gap: assert property (p_frozen_gap)
    else $error("freeze moved on a rising edge");

  // Counter moves only on a step or a clear
  property p_no_step;
    ce && !step && !clear_lvl |=> $stable(count_r);
  endproperty
  a_no_step: assert property (p_no_step) else $error("divider drifted");

  // The first rise after a low release is swallowed, and only that one
  property p_skip_hold;
    ce && skip_r && rise && !clear_lvl |=> $stable(count_r);
  endproperty
  a_skip_hold: assert property (p_skip_hold)
    else $error("skipped rise stepped");

  property p_skip_once;
    ce && skip_r && rise && !clear_lvl |=> !skip_r;
  endproperty
  a_skip_once: assert property (p_skip_once)
    else $error("skip outlived a rise");

  // Eighth leg only turns when the quarter leg falls or after a clear
  property p_aligned8;
    ce && !clear_lvl && $changed(count_r[EIGHTH_BIT]) |->
      $fell(count_r[QUARTER_BIT]) || $past(clear_lvl);
  endproperty
  a_aligned8: assert property (p_aligned8)
    else $error("eighth edge misaligned");

  c_wrap:   cover property (ce && step && count_r == ~COUNT_RESET);
  c_freeze: cover property (ce && freeze_r && rise);
  c_skip:   cover property (ce && skip_r && rise);
  c_clear:  cover property (ce && clear_r && !clear_lvl);
  c_rel_hi: cover property (ce && clear_r && !clear_lvl && clk_lvl);

endmodule : sync_clock_divider_2_4_8

`default_nettype wire

// [shared/clkdiv_pkg.sv]
// Constants and carrier types for the 2/4/8 synchronous clock divider.
// Assumes a single system clock; the divided clock input is a sampled level.
package clkdiv_pkg;

  // Divider chain geometry
  localparam int          DIV_BITS    = 3;
  localparam int          HALF_BIT    = 0;
  localparam int          QUARTER_BIT = 1;
  localparam int          EIGHTH_BIT  = 2;
  localparam logic [2:0]  COUNT_RESET = 3'h0;
  localparam logic [2:0]  COUNT_STEP  = 3'h1;
  localparam logic        FREEZE_RESET = 1'h0;

  // Sampled control pins of the divider
  typedef struct packed {
    logic clk_in;
    logic freeze;
    logic sync_clear;
  } ctrl_in_t;

  // Complementary divided outputs
  typedef struct packed {
    logic half_rate_out;
    logic half_rate_out_n;
    logic quarter_rate_out;
    logic quarter_rate_out_n;
    logic eighth_rate_out;
    logic eighth_rate_out_n;
  } div_out_t;

endpackage : clkdiv_pkg
